// file: inc/dtp_map.svh
`ifndef DTP_MAP_SVH
`define DTP_MAP_SVH
// register offsets
`define DTP_OFS_CTRL 16'hfe18
`define DTP_OFS_PRE 16'hfe19
`define DTP_OFS_LCNT 16'hfe1a
`define DTP_OFS_HCNT 16'hfe1b
`define DTP_OFS_LDATA 16'hfe1c
`define DTP_OFS_HDATA 16'hfe1d
// timer_control fields
`define DTP_B_HRUN 7
`define DTP_B_LRUN 6
`define DTP_B_CASC 5
`define DTP_B_MODE 4
`define DTP_B_HFLAG 3
`define DTP_B_HIE 2
`define DTP_B_LFLAG 1
`define DTP_B_LIE 0
// prescaler_control fields: high nibble high byte, low nibble low byte
`define DTP_B_HPRE_LSB 4
`define DTP_B_LPRE_LSB 0
// reset values
`define DTP_RST_CTRL 8'h00
`define DTP_RST_PRE 8'h00
`define DTP_RST_DATA 8'h00
// values with fixed meaning
`define DTP_FULL 8'hff
`define DTP_ZERO 8'h00
`endif

// file: inc/dtp_pkg.sv
package dtp_pkg;
  typedef logic [7:0] dtp_byte_t;
  typedef logic [3:0] dtp_pre_t;
  // counting arrangement, index {cascade, output mode}
  typedef enum logic [1:0] {DTP_M_TOG, DTP_M_PWM, DTP_M_CASC, DTP_M_CASC_PWM} dtp_mode_t;

  // last prescaler count for enable/field: 0 means divide by 1
  function automatic dtp_byte_t dtp_div_last(input dtp_pre_t sel);
    dtp_div_last = sel[3] ? (8'hff >> (3'h7 - sel[2:0])) : 8'h00;
  endfunction
endpackage

// file: inc/dtp_byte_if.sv
interface dtp_byte_if;
  import dtp_pkg::*;
  logic run;
  logic base_tick;
  logic clr_on_match;
  dtp_pre_t pre_sel;
  dtp_byte_t match_data;
  dtp_byte_t cnt;
  dtp_byte_t buf_val;
  logic match_ev;
  logic ovf_ev;
  logic zero_ev;
  modport ctl (output run, output base_tick, output clr_on_match, output pre_sel, output match_data,
    input cnt, input buf_val, input match_ev, input ovf_ev, input zero_ev);
  modport chan (input run, input base_tick, input clr_on_match, input pre_sel, input match_data,
    output cnt, output buf_val, output match_ev, output ovf_ev, output zero_ev);
endinterface

// file: logic/dtp_byte.sv
`include "dtp_map.svh"
module dtp_byte
  import dtp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  dtp_byte_if.chan bi
);
  dtp_pre_t pre_act_r;
  dtp_byte_t pre_cnt_r;
  dtp_byte_t cnt_r;
  dtp_byte_t buf_r;
  logic tick;
  logic hit;

  assign tick = bi.run && bi.base_tick && (pre_cnt_r == dtp_div_last(pre_act_r));
  assign hit = (cnt_r == buf_r);
  assign bi.cnt = cnt_r;
  assign bi.buf_val = buf_r;
  assign bi.match_ev = tick && hit;
  assign bi.ovf_ev = tick && (cnt_r == `DTP_FULL);
  // reaching zero: wrap from full or clear on match
  assign bi.zero_ev = tick && ((hit && bi.clr_on_match) || cnt_r == `DTP_FULL);

  // new prescale only at buffer reload, so a period is never cut short
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pre_act_r <= 4'h0;
    else if (!bi.run || bi.zero_ev) pre_act_r <= bi.pre_sel;
  end

  // prescaler restarts with the counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) pre_cnt_r <= 8'h00;
    else if (!bi.run || tick) pre_cnt_r <= 8'h00;
    else if (bi.base_tick) pre_cnt_r <= pre_cnt_r + 8'h01;
  end

  // counter: held at zero while stopped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) cnt_r <= 8'h00;
    else if (!bi.run) cnt_r <= 8'h00;
    else if (tick) cnt_r <= (hit && bi.clr_on_match) ? 8'h00 : cnt_r + 8'h01;
  end

  // match buffer: follows data while stopped, reloads at zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) buf_r <= `DTP_RST_DATA;
    else if (!bi.run || bi.zero_ev) buf_r <= bi.match_data;
  end

  sequence s_tick_miss;
    bi.run && tick && !hit;
  endsequence

  property p_count_up;
    @(posedge clock) disable iff (!nrst) s_tick_miss |=> cnt_r == $past(cnt_r) + 8'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not advance on tick");

  property p_clear_match;
    @(posedge clock) disable iff (!nrst) (bi.run && bi.match_ev && bi.clr_on_match) |=> cnt_r == 8'h00;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("counter not cleared on match");

  property p_buf_reload;
    @(posedge clock) disable iff (!nrst) (bi.run && !bi.zero_ev) |=> buf_r == $past(buf_r);
  endproperty
  a_buf_reload: assert property (p_buf_reload) else $error("buffer changed away from zero");
endmodule

// file: logic/dtp_top.sv
// The strobed register port was chosen for this implementation.
`include "dtp_map.svh"
module dtp_top
  import dtp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic low_output_pin,
  output logic high_output_pin,
  output logic irq
);
  dtp_byte_t timer_control_r;
  dtp_byte_t prescaler_control_r;
  dtp_byte_t low_match_data_r;
  dtp_byte_t high_match_data_r;
  dtp_byte_t rdata_r;
  logic half_r;
  logic low_pin_r;
  logic high_pin_r;
  logic irq_r;
  logic high_base;
  logic low_flag_nxt;
  logic high_flag_nxt;
  dtp_mode_t mode;

  dtp_byte_if lo_if();
  dtp_byte_if hi_if();

  // control fields
  logic high_run_control;
  logic low_run_control;
  logic cascade_select;
  logic output_mode_select;
  logic high_match_flag;
  logic high_irq_enable;
  logic low_match_flag;
  logic low_irq_enable;

  assign high_run_control = timer_control_r[`DTP_B_HRUN];
  assign low_run_control = timer_control_r[`DTP_B_LRUN];
  assign cascade_select = timer_control_r[`DTP_B_CASC];
  assign output_mode_select = timer_control_r[`DTP_B_MODE];
  assign high_match_flag = timer_control_r[`DTP_B_HFLAG];
  assign high_irq_enable = timer_control_r[`DTP_B_HIE];
  assign low_match_flag = timer_control_r[`DTP_B_LFLAG];
  assign low_irq_enable = timer_control_r[`DTP_B_LIE];
  assign mode = dtp_mode_t'({cascade_select, output_mode_select});

  // write decode shared by several registers
  function automatic logic wr_hit(input logic w, input logic [15:0] a, input logic [15:0] ofs);
    wr_hit = w && (a == ofs);
  endfunction

  // divide-by-two reference, free running so both bytes share phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) half_r <= 1'b0;
    else half_r <= ~half_r;
  end

  // low byte hookup
  assign lo_if.run = low_run_control;
  assign lo_if.base_tick = output_mode_select ? 1'b1 : half_r;
  assign lo_if.clr_on_match = !output_mode_select;
  assign lo_if.pre_sel = prescaler_control_r[`DTP_B_LPRE_LSB +: 4];
  assign lo_if.match_data = low_match_data_r;

  // high byte source: own clock, or the low period when cascaded
  always_comb begin
    case (mode)
      DTP_M_TOG: high_base = half_r;
      DTP_M_PWM: high_base = 1'b1;
      DTP_M_CASC: high_base = lo_if.match_ev;
      DTP_M_CASC_PWM: high_base = lo_if.ovf_ev;
      default: high_base = 1'b0;
    endcase
  end

  assign hi_if.run = high_run_control;
  assign hi_if.base_tick = high_base;
  assign hi_if.clr_on_match = (mode != DTP_M_PWM);
  assign hi_if.pre_sel = prescaler_control_r[`DTP_B_HPRE_LSB +: 4];
  assign hi_if.match_data = high_match_data_r;

  dtp_byte u_low (
    .clock(clock),
    .nrst(nrst),
    .bi(lo_if.chan)
  );

  dtp_byte u_high (
    .clock(clock),
    .nrst(nrst),
    .bi(hi_if.chan)
  );

  // flags: a zero event in the clearing cycle wins
  always_comb begin
    low_flag_nxt = low_match_flag;
    high_flag_nxt = high_match_flag;
    if (wr_hit(wr, addr, `DTP_OFS_CTRL)) begin
      low_flag_nxt = low_match_flag && wdata[`DTP_B_LFLAG];
      high_flag_nxt = high_match_flag && wdata[`DTP_B_HFLAG];
    end
    if (low_run_control && lo_if.zero_ev) low_flag_nxt = 1'b1;
    if (high_run_control && hi_if.zero_ev) high_flag_nxt = 1'b1;
  end

  // timer_control: software writing 1 to a flag leaves it as is
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_control_r <= `DTP_RST_CTRL;
    end else begin
      if (wr_hit(wr, addr, `DTP_OFS_CTRL)) begin
        timer_control_r[7:4] <= wdata[7:4];
        timer_control_r[`DTP_B_HIE] <= wdata[`DTP_B_HIE];
        timer_control_r[`DTP_B_LIE] <= wdata[`DTP_B_LIE];
      end
      timer_control_r[`DTP_B_HFLAG] <= high_flag_nxt;
      timer_control_r[`DTP_B_LFLAG] <= low_flag_nxt;
    end
  end

  // prescaler_control; the bytes pick it up at reload time
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) prescaler_control_r <= `DTP_RST_PRE;
    else if (wr_hit(wr, addr, `DTP_OFS_PRE)) prescaler_control_r <= wdata;
  end

  // match data registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      low_match_data_r <= `DTP_RST_DATA;
      high_match_data_r <= `DTP_RST_DATA;
    end else begin
      if (wr_hit(wr, addr, `DTP_OFS_LDATA)) low_match_data_r <= wdata;
      if (wr_hit(wr, addr, `DTP_OFS_HDATA)) high_match_data_r <= wdata;
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      case (addr)
        `DTP_OFS_CTRL: rdata_r <= timer_control_r;
        `DTP_OFS_PRE: rdata_r <= prescaler_control_r;
        `DTP_OFS_LCNT: rdata_r <= lo_if.cnt;
        `DTP_OFS_HCNT: rdata_r <= hi_if.cnt;
        `DTP_OFS_LDATA: rdata_r <= low_match_data_r;
        `DTP_OFS_HDATA: rdata_r <= high_match_data_r;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // low pin: fixed levels first, then toggle or pwm edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) low_pin_r <= 1'b1;
    else if (!low_run_control) low_pin_r <= 1'b1;
    else if (low_match_data_r == `DTP_FULL) low_pin_r <= 1'b0;
    else if (!output_mode_select) begin
      if (lo_if.match_ev) low_pin_r <= ~low_pin_r;
    end else begin
      if (lo_if.ovf_ev) low_pin_r <= 1'b0;
      else if (lo_if.match_ev) low_pin_r <= 1'b1;
    end
  end

  // high pin: pwm only when not cascaded
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) high_pin_r <= 1'b1;
    else if (!high_run_control) high_pin_r <= 1'b1;
    else if (high_match_data_r == `DTP_FULL) high_pin_r <= 1'b0;
    else if (!output_mode_select || cascade_select) begin
      if (hi_if.match_ev) high_pin_r <= ~high_pin_r;
    end else begin
      if (hi_if.ovf_ev) high_pin_r <= 1'b0;
      else if (hi_if.match_ev) high_pin_r <= 1'b1;
    end
  end

  // one shared request, registered so it is glitch free
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) irq_r <= 1'b0;
    else irq_r <= (high_match_flag && high_irq_enable) || (low_match_flag && low_irq_enable);
  end

  assign rdata = rdata_r;
  assign low_output_pin = low_pin_r;
  assign high_output_pin = high_pin_r;
  assign irq = irq_r;

  // checks
  property p_high_stop;
    @(posedge clock) disable iff (!nrst) !high_run_control |=> hi_if.cnt == 8'h00;
  endproperty
  a_high_stop: assert property (p_high_stop) else $error("high counter not held at zero");

  property p_low_stop;
    @(posedge clock) disable iff (!nrst) !low_run_control |=> lo_if.cnt == 8'h00;
  endproperty
  a_low_stop: assert property (p_low_stop) else $error("low counter not held at zero");

  property p_high_buf_follow;
    @(posedge clock) disable iff (!nrst) !high_run_control |=> hi_if.buf_val == $past(high_match_data_r);
  endproperty
  a_high_buf_follow: assert property (p_high_buf_follow) else $error("high buffer not following");

  property p_low_pin_stop;
    @(posedge clock) disable iff (!nrst) !low_run_control |=> low_output_pin;
  endproperty
  a_low_pin_stop: assert property (p_low_pin_stop) else $error("low pin not high while stopped");

  property p_high_pin_full;
    @(posedge clock) disable iff (!nrst)
      (high_run_control && high_match_data_r == 8'hff) |=> !high_output_pin;
  endproperty
  a_high_pin_full: assert property (p_high_pin_full) else $error("high pin not low at full data");

  sequence s_low_toggle_cause;
    low_run_control && !output_mode_select && lo_if.match_ev && low_match_data_r != 8'hff;
  endsequence

  property p_low_toggle;
    @(posedge clock) disable iff (!nrst) s_low_toggle_cause |=> low_output_pin != $past(low_output_pin);
  endproperty
  a_low_toggle: assert property (p_low_toggle) else $error("low pin missed a toggle");

  property p_low_pwm_ovf;
    @(posedge clock) disable iff (!nrst)
      (low_run_control && output_mode_select && lo_if.ovf_ev) |=> !low_output_pin;
  endproperty
  a_low_pwm_ovf: assert property (p_low_pwm_ovf) else $error("low pin not cleared on overflow");

  property p_high_pwm_match;
    @(posedge clock) disable iff (!nrst)
      (high_run_control && mode == DTP_M_PWM && hi_if.match_ev && !hi_if.ovf_ev
       && high_match_data_r != 8'hff) |=> high_output_pin;
  endproperty
  a_high_pwm_match: assert property (p_high_pwm_match) else $error("high pin not set on match");

  sequence s_high_zero;
    high_run_control && hi_if.zero_ev;
  endsequence

  // flag holds into the second cycle unless software cleared it in the first
  property p_high_flag;
    @(posedge clock) disable iff (!nrst) s_high_zero |=> high_match_flag
      ##1 (high_match_flag || $past(wr && addr == `DTP_OFS_CTRL && !wdata[`DTP_B_HFLAG]));
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag not set and held");

  sequence s_low_clear_quiet;
    wr && addr == 16'hfe18 && !wdata[1] && !(low_run_control && lo_if.zero_ev);
  endsequence

  property p_low_flag_clear;
    @(posedge clock) disable iff (!nrst) s_low_clear_quiet |=> !low_match_flag;
  endproperty
  a_low_flag_clear: assert property (p_low_flag_clear) else $error("low flag clear failed");

  property p_irq;
    @(posedge clock) disable iff (!nrst)
      ((low_match_flag && low_irq_enable) || (high_match_flag && high_irq_enable)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_quiet;
    @(posedge clock) disable iff (!nrst)
      !((low_match_flag && low_irq_enable) || (high_match_flag && high_irq_enable)) |=> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

  property p_cascade_step;
    @(posedge clock) disable iff (!nrst) (mode == DTP_M_CASC && !lo_if.match_ev) |-> !hi_if.match_ev;
  endproperty
  a_cascade_step: assert property (p_cascade_step) else $error("high byte moved without low period");

  property p_rd_zero;
    @(posedge clock) disable iff (!nrst) !rd |=> rdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside read slot");
endmodule

// file: verification/dtp_top_tb.sv
`include "dtp_map.svh"
module dtp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} dtp_row_t;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic low_output_pin;
  logic high_output_pin;
  logic irq;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] rv;
  dtp_row_t rows [0:7];
  logic [15:0] rst_a [0:3];

  dtp_top dut (
    .clock(clock),
    .nrst(nrst),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .low_output_pin(low_output_pin),
    .high_output_pin(high_output_pin),
    .irq(irq)
  );

  // 10 mhz cycle clock
  always #50 clock = ~clock;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // longest test is the prescale sweep, about 8k cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      miscompares++;
      $display("timeout after %0d cycles", cyc);
      end_sim();
    end
  end

  // one-cycle strobes, launched right after an edge
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp);
    checked++;
    if (got != exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  function automatic logic pin(input bit hi);
    return hi ? high_output_pin : low_output_pin;
  endfunction

  // length in cycles of the next whole stretch at level lvl; skips a partial one
  task automatic seg(input bit hi, input logic lvl, output int len);
    int i;
    i = 0;
    while (pin(hi) === lvl && i < 20000) begin
      step(1);
      i++;
    end
    while (pin(hi) !== lvl && i < 20000) begin
      step(1);
      i++;
    end
    len = 0;
    while (pin(hi) === lvl && len < 20000) begin
      step(1);
      len++;
    end
  endtask

  initial begin
    // ctrl write of 3f: flags cannot be set by software
    rows = '{'{`DTP_OFS_PRE, 8'ha5, 8'ha5}, '{`DTP_OFS_LDATA, 8'h37, 8'h37},
      '{`DTP_OFS_HDATA, 8'hc4, 8'hc4}, '{`DTP_OFS_CTRL, 8'h3f, 8'h35},
      '{`DTP_OFS_CTRL, 8'h00, 8'h00}, '{`DTP_OFS_LCNT, 8'h77, 8'h00},
      '{`DTP_OFS_HCNT, 8'h77, 8'h00}, '{16'hfe20, 8'h5a, 8'h00}};
    rst_a = '{`DTP_OFS_CTRL, `DTP_OFS_PRE, `DTP_OFS_LDATA, `DTP_OFS_HDATA};
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    step(1);
    chk_bit(low_output_pin, 1'b1);
    chk_bit(high_output_pin, 1'b1);
    chk_bit(irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd_reg(rst_a[i], rv);
      chk_byte(rv, 8'h00);
    end
    $display("test reset done");
    // table of write then read-back, incl. read-only and unmapped places
    for (int i = 0; i < 8; i++) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rv);
      chk_byte(rv, rows[i].e);
    end
    $display("test registers done");
    // low byte toggle, mode 0, half rate base
    wr_reg(`DTP_OFS_PRE, 8'h00);
    wr_reg(`DTP_OFS_LDATA, 8'h03);
    wr_reg(`DTP_OFS_CTRL, 8'h41);
    seg(1'b0, 1'b1, n);
    chk_count(n, 8);
    seg(1'b0, 1'b0, n);
    chk_count(n, 8);
    chk_bit(high_output_pin, 1'b1);
    rd_reg(`DTP_OFS_CTRL, rv);
    chk_byte(rv, 8'h43);
    chk_bit(irq, 1'b1);
    // new match data only takes over at the next zero
    wr_reg(`DTP_OFS_LDATA, 8'h07);
    seg(1'b0, 1'b1, n);
    seg(1'b0, 1'b1, n);
    chk_count(n, 16);
    wr_reg(`DTP_OFS_CTRL, 8'h03);
    step(2);
    rd_reg(`DTP_OFS_CTRL, rv);
    chk_byte(rv, 8'h03);
    chk_bit(irq, 1'b1);
    chk_bit(low_output_pin, 1'b1);
    rd_reg(`DTP_OFS_LCNT, rv);
    chk_byte(rv, 8'h00);
    wr_reg(`DTP_OFS_CTRL, 8'h01);
    step(2);
    chk_bit(irq, 1'b0);
    rd_reg(`DTP_OFS_CTRL, rv);
    chk_byte(rv, 8'h01);
    $display("test low toggle done");
    // high byte alone, toggle then pwm
    wr_reg(`DTP_OFS_HDATA, 8'h02);
    wr_reg(`DTP_OFS_CTRL, 8'h80);
    seg(1'b1, 1'b1, n);
    chk_count(n, 6);
    chk_bit(low_output_pin, 1'b1);
    rd_reg(`DTP_OFS_CTRL, rv);
    chk_byte(rv, 8'h88);
    chk_bit(irq, 1'b0);
    wr_reg(`DTP_OFS_HDATA, 8'h0f);
    wr_reg(`DTP_OFS_CTRL, 8'h90);
    seg(1'b1, 1'b0, n);
    chk_count(n, 16);
    seg(1'b1, 1'b1, n);
    chk_count(n, 240);
    $display("test high byte done");
    // data of ff forces both pins low while running
    wr_reg(`DTP_OFS_LDATA, 8'hff);
    wr_reg(`DTP_OFS_HDATA, 8'hff);
    wr_reg(`DTP_OFS_CTRL, 8'hd0);
    step(300);
    chk_bit(low_output_pin, 1'b0);
    chk_bit(high_output_pin, 1'b0);
    wr_reg(`DTP_OFS_CTRL, 8'h00);
    step(2);
    chk_bit(low_output_pin, 1'b1);
    chk_bit(high_output_pin, 1'b1);
    rd_reg(`DTP_OFS_HCNT, rv);
    chk_byte(rv, 8'h00);
    $display("test forced levels done");
    // cascade, toggle outputs: high counts low matches
    wr_reg(`DTP_OFS_LDATA, 8'h01);
    wr_reg(`DTP_OFS_HDATA, 8'h01);
    wr_reg(`DTP_OFS_CTRL, 8'he4);
    seg(1'b0, 1'b1, n);
    chk_count(n, 4);
    seg(1'b1, 1'b1, n);
    chk_count(n, 8);
    rd_reg(`DTP_OFS_CTRL, rv);
    chk_byte(rv, 8'hee);
    chk_bit(irq, 1'b1);
    // cascade with low pwm: high counts low overflows, still toggles
    wr_reg(`DTP_OFS_LDATA, 8'h7f);
    wr_reg(`DTP_OFS_HDATA, 8'h00);
    wr_reg(`DTP_OFS_CTRL, 8'hf0);
    seg(1'b0, 1'b0, n);
    chk_count(n, 128);
    seg(1'b1, 1'b1, n);
    chk_count(n, 256);
    $display("test cascade done");
    // prescale sweep in pwm: low stretch is one count of the prescaler
    wr_reg(`DTP_OFS_LDATA, 8'h00);
    wr_reg(`DTP_OFS_CTRL, 8'h50);
    for (int f = -1; f < 5; f++) begin
      wr_reg(`DTP_OFS_PRE, (f < 0) ? 8'h00 : {5'h01, f[2:0]});
      step(2);
      seg(1'b0, 1'b0, n);
      chk_count(n, (f < 0) ? 1 : (1 << (f + 1)));
    end
    $display("test prescale done");
    // reset in mid-run: registers written above must all come back as zero
    @(posedge clock);
    nrst <= 1'b0;
    step(2);
    chk_bit(low_output_pin, 1'b1);
    chk_bit(high_output_pin, 1'b1);
    chk_bit(irq, 1'b0);
    @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_reg(rst_a[i], rv);
      chk_byte(rv, 8'h00);
    end
    rd_reg(`DTP_OFS_LCNT, rv);
    chk_byte(rv, 8'h00);
    wr_reg(`DTP_OFS_CTRL, 8'h00);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
